//--- verilog/mmc_ctrl.sv
// memory module mode controller: standard, configuration and executing modes
// Contract
// - after power-up the module is in standard mode, acting as plain memory
// - configuration only from standard, after toggle pattern then signature, in order
// - in configuration, control registers answer as host memory locations
// - register region sits above memory starting at the power-up address
// - registers steer shared memory, processor mailbox, program run, status
// - access to the execute register moves configuration to executing
// - executing keeps all configuration register behaviour, processor runs
// - host can return to standard from configuration or executing any time
// - leaving executing halts the processor at once
// - interrupt line requests an interrupt from the host
// - stall line asks the host to stall the access in progress
// - separate clock enables for low and high shared memory halves
// - data path switches controlled per 8-bit group
// - processor gets 32-bit shared data bus with 4-bit byte mask
// - read or wrong write to power-up address discards partial signature
// - interrupt line is input in standard, open-drain output otherwise
// - return to standard lands in the signature-waiting state directly
`timescale 1ns/1ps
`default_nettype none
`include "mmc_map.svh"
module mmc_ctrl (
  input wire logic clk_sys_i,                     // 200 MHz module clock
  input wire logic rst_i,                         // synchronous reset, high
  input wire mmc_pkg::mmc_host_req_t host_req_i,  // decoded host access, one-cycle valid
  input wire logic irq_line_i,                    // interrupt line level from the pin
  input wire logic proc_irq_i,                    // processor asks for host interrupt
  input wire logic proc_busy_i,                   // processor holds shared memory
  input wire logic [31:0] proc_data_i,            // processor shared data in
  output logic irq_line_o,                        // interrupt line drive value (low)
  output logic irq_line_oe_o,                     // interrupt line drive enable
  output logic stall_o,                           // stall request to host
  output logic shared_clk_en_lo_o,                // clock enable, low half
  output logic shared_clk_en_hi_o,                // clock enable, high half
  output logic [15:0] data_path_switches_o,       // one bit per 8-bit group
  output mmc_pkg::mmc_proc_bus_t proc_bus_o,      // shared data and byte mask to processor
  output logic proc_run_o,                        // processor run enable
  output logic [63:0] rd_data_o,                  // register read data
  output logic rd_valid_o,                        // register read answer
  output mmc_pkg::mmc_mode_t mode_o               // current mode
);
  // ----------------------------------------
  // pin synchroniser and toggle pattern check
  // ----------------------------------------
  logic irq_m;
  logic irq_s;
  logic irq_d;
  logic [15:0] win_cnt;
  logic [7:0] ph_cnt;
  logic [2:0] fall_cnt;
  logic ph_ok;
  logic toggle_seen;
  mmc_pkg::mmc_mode_t mode;
  wire fall = irq_d & ~irq_s;
  wire edge_any = irq_d ^ irq_s;
  // a phase of n cycles shows n-1 here at its closing edge, so a 100 ns phase still passes
  wire ph_long = (ph_cnt >= 8'(`MMC_TPHASE_CYC - 1));

  always_ff @(posedge clk_sys_i)
  begin
    irq_m <= irq_line_i;
    irq_s <= irq_m;
    irq_d <= irq_s;
  end

  // phase length counter, saturating
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || edge_any)
      ph_cnt <= 8'h00;
    else if (!ph_long)
      ph_cnt <= ph_cnt + 8'h01;
  end

  // a short phase or an expired window scraps the attempt
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || mode != mmc_pkg::MMC_IDLE)
    begin
      win_cnt <= 16'h0000;
      fall_cnt <= 3'h0;
      ph_ok <= 1'b0;
    end
    else if (edge_any && !ph_long && fall_cnt != 3'h0)
    begin
      win_cnt <= 16'h0000;
      fall_cnt <= 3'h0;
      ph_ok <= 1'b0;
    end
    else if (fall)
    begin
      fall_cnt <= (fall_cnt == 3'h0 || ph_ok) ? fall_cnt + 3'h1 : 3'h1;
      win_cnt <= (fall_cnt == 3'h0) ? 16'h0001 : win_cnt + 16'h0001;
      ph_ok <= 1'b1;
    end
    else if (fall_cnt != 3'h0)
    begin
      if (win_cnt >= 16'(`MMC_TSEQ_CYC))
      begin
        win_cnt <= 16'h0000;
        fall_cnt <= 3'h0;
        ph_ok <= 1'b0;
      end
      else
        win_cnt <= win_cnt + 16'h0001;
    end
  end

  // the closing fall must follow a long enough high phase as well
  wire toggle_done = (mode == mmc_pkg::MMC_IDLE) && fall && ph_ok && ph_long &&
                     (fall_cnt == 3'(`MMC_NEDGE - 1));

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      toggle_seen <= 1'b0;
    else if (toggle_done)
      toggle_seen <= 1'b1;
  end

  // ----------------------------------------
  // signature capture
  // ----------------------------------------
  logic [5:0] sig_idx;
  wire [`MMC_MON_MSB:`MMC_MON_LSB] mon = host_req_i.data[`MMC_MON_MSB:`MMC_MON_LSB];
  wire mon_ones = &mon;
  wire mon_zeros = ~|mon;
  logic [`MMC_SIG_LEN-1:0] sig_code;
  assign sig_code = `MMC_SIG_CODE;
  wire exp_bit = sig_code[6'(`MMC_SIG_LEN - 1) - sig_idx];
  wire at_pwrup = host_req_i.valid && host_req_i.addr == `MMC_PWRUP_ADDR;
  wire sig_good = host_req_i.write && (exp_bit ? mon_ones : mon_zeros);
  wire sig_done = (mode == mmc_pkg::MMC_IDLE2) && at_pwrup && sig_good &&
                  sig_idx == 6'(`MMC_SIG_LEN - 1);

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || mode != mmc_pkg::MMC_IDLE2)
      sig_idx <= 6'h00;
    else if (at_pwrup)
      sig_idx <= (sig_good && !sig_done) ? sig_idx + 6'h01 : 6'h00;
  end

  // ----------------------------------------
  // mode register and memory-mapped registers
  // ----------------------------------------
  wire reg_on = (mode == mmc_pkg::MMC_CONFIG) || (mode == mmc_pkg::MMC_EXEC);
  wire reg_wr = reg_on && host_req_i.valid && host_req_i.write;
  wire reg_rd = reg_on && host_req_i.valid && !host_req_i.write;
  wire go_std = reg_wr && host_req_i.addr == `MMC_REG_MODE &&
                host_req_i.data[1:0] == `MMC_MODE_STD;
  wire go_exec = reg_on && host_req_i.valid && host_req_i.addr == `MMC_REG_EXEC;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      mode <= mmc_pkg::MMC_IDLE;
    else
    begin
      case (mode)
        mmc_pkg::MMC_IDLE:
          if (toggle_done)
            mode <= mmc_pkg::MMC_IDLE2;
        mmc_pkg::MMC_IDLE2:
          if (sig_done)
            mode <= mmc_pkg::MMC_CONFIG;
        mmc_pkg::MMC_CONFIG:
          if (go_std)
            mode <= toggle_seen ? mmc_pkg::MMC_IDLE2 : mmc_pkg::MMC_IDLE;
          else if (go_exec)
            mode <= mmc_pkg::MMC_EXEC;
        mmc_pkg::MMC_EXEC:
          if (go_std)
            mode <= mmc_pkg::MMC_IDLE2;
        default:
          mode <= mmc_pkg::MMC_IDLE;
      endcase
    end
  end

  // registers only decode above the memory, from the power-up address on
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      data_path_switches_o <= 16'h0000;
      shared_clk_en_lo_o <= 1'b0;
      shared_clk_en_hi_o <= 1'b0;
    end
    else if (!reg_on)
    begin
      data_path_switches_o <= 16'h0000;
      shared_clk_en_lo_o <= 1'b0;
      shared_clk_en_hi_o <= 1'b0;
    end
    else if (reg_wr && host_req_i.addr == `MMC_REG_SWITCH)
      data_path_switches_o <= host_req_i.data[15:0];
    else if (reg_wr && host_req_i.addr == `MMC_REG_CKE)
    begin
      shared_clk_en_lo_o <= host_req_i.data[0];
      shared_clk_en_hi_o <= host_req_i.data[1];
    end
  end

  // leaving executing mode drops run in the same edge as the mode change
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      proc_run_o <= 1'b0;
    else
      proc_run_o <= (mode == mmc_pkg::MMC_EXEC && !go_std) ||
                    (mode == mmc_pkg::MMC_CONFIG && go_exec && !go_std);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      rd_data_o <= 64'h0;
      rd_valid_o <= 1'b0;
    end
    else
    begin
      rd_valid_o <= reg_rd && host_req_i.addr >= `MMC_PWRUP_ADDR;
      case (host_req_i.addr)
        `MMC_REG_MODE: rd_data_o <= {62'h0, mode};
        `MMC_REG_SWITCH: rd_data_o <= {48'h0, data_path_switches_o};
        `MMC_REG_CKE: rd_data_o <= {62'h0, shared_clk_en_hi_o, shared_clk_en_lo_o};
        `MMC_REG_EXEC: rd_data_o <= {32'h0, proc_data_i};
        default: rd_data_o <= 64'h0;
      endcase
    end
  end

  // ----------------------------------------
  // card-edge outputs and processor bus
  // ----------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      irq_line_o <= 1'b0;
      irq_line_oe_o <= 1'b0;
      stall_o <= 1'b0;
      proc_bus_o <= '0;
    end
    else
    begin
      irq_line_o <= 1'b0;
      irq_line_oe_o <= reg_on && proc_irq_i;
      stall_o <= reg_on && proc_busy_i && host_req_i.valid;
      proc_bus_o.data <= host_req_i.data[31:0];
      proc_bus_o.mask <= {4{reg_wr}};
      proc_bus_o.valid <= reg_wr && host_req_i.addr > `MMC_REG_CKE;
    end
  end

  assign mode_o = mode;
endmodule
`default_nettype wire

//--- inc/mmc_map.svh
// offsets, field positions, mode codes and timing counts for the mode controller
`ifndef MMC_MAP_SVH
`define MMC_MAP_SVH
// ----------------------------------------
// timing of the host toggle pattern
// ----------------------------------------
`define MMC_CLK_MHZ 200
`define MMC_TSEQ_NS 5000
`define MMC_TPHASE_NS 100
`define MMC_NEDGE 5
// longest window rounds down, least phase rounds up
`define MMC_TSEQ_CYC ((`MMC_TSEQ_NS * `MMC_CLK_MHZ) / 1000)
`define MMC_TPHASE_CYC (((`MMC_TPHASE_NS * `MMC_CLK_MHZ) + 999) / 1000)
// ----------------------------------------
// signature and register window
// ----------------------------------------
`define MMC_SIG_LEN 48
`define MMC_SIG_CODE 48'h424153415641
`define MMC_MON_LSB 0
`define MMC_MON_MSB 7
`define MMC_PWRUP_ADDR 32'h1000_0000
`define MMC_REG_MODE 32'h1000_0000
`define MMC_REG_EXEC 32'h1000_0008
`define MMC_REG_SWITCH 32'h1000_0010
`define MMC_REG_CKE 32'h1000_0018
`define MMC_MODE_STD 2'h0
`define MMC_MODE_EXEC 2'h2
`endif

//--- inc/mmc_pkg.sv
// types shared by the memory module mode controller
`default_nettype none
package mmc_pkg;
  typedef enum logic [1:0] {
    MMC_IDLE = 2'b00,
    MMC_IDLE2 = 2'b01,
    MMC_CONFIG = 2'b11,
    MMC_EXEC = 2'b10
  } mmc_mode_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [63:0] data;
  } mmc_host_req_t;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0] mask;
    logic valid;
  } mmc_proc_bus_t;
endpackage
`default_nettype wire

//--- dv/mmc_host_model.sv
// host-side model: drives the toggle pattern and resolves the interrupt line
`timescale 1ns/1ps
`default_nettype none
module mmc_host_model (
  input wire logic clk_i,    // module clock
  input wire logic dev_oe_i, // device pulls the line low
  output logic line_o        // resolved line level
);
  logic host_low = 1'b0;
  // pulled up, so a released line reads high; host never drives high
  assign line_o = !(host_low || dev_oe_i);
  // phase length in cycles, so short phases can be sent on purpose
  task automatic toggle(input int n, input int ph);
    repeat (n)
    begin
      repeat (ph) @(posedge clk_i);
      host_low <= 1'b1;
      repeat (ph) @(posedge clk_i);
      host_low <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

//--- dv/mmc_ctrl_props.sv
// port assertions for the mode controller
`timescale 1ns/1ps
`default_nettype none
`include "mmc_map.svh"
module mmc_ctrl_props (
  input wire logic clk_sys_i,                    // clock
  input wire logic rst_i,                        // reset
  input wire mmc_pkg::mmc_host_req_t host_req_i, // host access
  input wire logic proc_busy_i,                  // processor owns memory
  input wire logic irq_line_oe_o,                // line enable
  input wire logic stall_o,                      // stall
  input wire logic shared_clk_en_lo_o,           // enable low
  input wire logic shared_clk_en_hi_o,           // enable high
  input wire logic proc_run_o,                   // run
  input wire logic rd_valid_o,                   // read answer
  input wire mmc_pkg::mmc_mode_t mode_o          // mode
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  logic cfg;
  logic rq;
  // config and executing share the top mode bit
  assign cfg = mode_o[1];
  assign rq = host_req_i.valid;
  chk_cfg_entry: assert property (mode_o == mmc_pkg::MMC_CONFIG && !$past(cfg) |->
    $past(mode_o) == mmc_pkg::MMC_IDLE2 && $past(rq && host_req_i.write)) else $error("bad cfg");
  chk_exec_entry: assert property (mode_o == mmc_pkg::MMC_EXEC && $past(mode_o) != mode_o |->
    $past(rq && host_req_i.addr == `MMC_REG_EXEC) && $past(mode_o[0])) else $error("bad exec");
  chk_std_return: assert property ($past(cfg) && !cfg |-> mode_o == mmc_pkg::MMC_IDLE2)
    else $error("bad return");
  chk_run_off: assert property (mode_o != mmc_pkg::MMC_EXEC |-> !proc_run_o)
    else $error("run outside exec");
  chk_run_on: assert property (mode_o == mmc_pkg::MMC_EXEC [*2] |-> proc_run_o)
    else $error("no run");
  chk_oe_std: assert property (!cfg [*2] |-> !irq_line_oe_o)
    else $error("line driven in standard");
  chk_rd_answer: assert property (cfg && rq && !host_req_i.write &&
    host_req_i.addr >= `MMC_PWRUP_ADDR |=> rd_valid_o) else $error("no answer");
  chk_stall_cause: assert property (stall_o |-> $past(cfg && rq && proc_busy_i))
    else $error("bad stall");
  chk_clk_std: assert property (!cfg [*2] |-> !shared_clk_en_lo_o && !shared_clk_en_hi_o)
    else $error("clock enable in standard");
endmodule
bind mmc_ctrl mmc_ctrl_props chk_u (.clk_sys_i, .rst_i, .host_req_i, .proc_busy_i,
  .irq_line_oe_o, .stall_o, .shared_clk_en_lo_o, .shared_clk_en_hi_o, .proc_run_o,
  .rd_valid_o, .mode_o);
`default_nettype wire

//--- dv/tb_memory_module_mode_control.sv
// testbench for the memory module mode controller
`timescale 1ns/1ps
`default_nettype none
`include "mmc_map.svh"
module tb_memory_module_mode_control;
  localparam logic [47:0] SIG = `MMC_SIG_CODE;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  mmc_pkg::mmc_host_req_t rq = '0;
  logic busy = 1'b0;
  logic pirq = 1'b0;
  logic [31:0] pdat = 32'h0000_5a3c;
  logic line;
  logic oe, run, stall, rdv, clo, chi, s;
  logic irq_o;
  logic [15:0] sw;
  logic [63:0] rdd;
  mmc_pkg::mmc_proc_bus_t pb;
  mmc_pkg::mmc_mode_t mode;
  int n_errors = 0;
  int checked = 0;
  mmc_ctrl dut_u (.clk_sys_i, .rst_i, .host_req_i(rq), .irq_line_i(line), .proc_irq_i(pirq),
    .proc_busy_i(busy), .proc_data_i(pdat), .irq_line_o(irq_o), .irq_line_oe_o(oe),
    .stall_o(stall), .shared_clk_en_lo_o(clo), .shared_clk_en_hi_o(chi),
    .data_path_switches_o(sw), .proc_bus_o(pb), .proc_run_o(run), .rd_data_o(rdd),
    .rd_valid_o(rdv), .mode_o(mode));
  mmc_host_model host_u (.clk_i(clk_sys_i), .dev_oe_i(oe), .line_o(line));
  initial
  begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // returns just after the sampling edge, where answers have landed
  task automatic bus(input logic w, input logic [31:0] a, input logic [63:0] d);
    @(posedge clk_sys_i);
    rq <= '{1'b1, w, a, d};
    @(posedge clk_sys_i);
    rq.valid <= 1'b0;
    #1;
  endtask
  task automatic sig(input int lo, input int hi);
    for (int i = hi; i >= lo; i--) bus(1'b1, `MMC_PWRUP_ADDR, {64{SIG[i]}});
  endtask
  task automatic close_out;
    $display("checks=%0d errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_std;
    chk(mode, mmc_pkg::MMC_IDLE);
    chk({run, stall, oe, clo, chi, rdv}, 6'h00);
    sig(0, 47);
    chk(mode, mmc_pkg::MMC_IDLE);
  endtask
  task automatic t_tog;
    // one cycle short of the least phase must be refused, the least phase itself taken
    host_u.toggle(5, 19);
    wait_n(20);
    chk(mode, mmc_pkg::MMC_IDLE);
    host_u.toggle(4, 25);
    wait_n(1100);
    chk(mode, mmc_pkg::MMC_IDLE);
    host_u.toggle(5, 20);
    wait_n(20);
    chk(mode, mmc_pkg::MMC_IDLE2);
  endtask
  task automatic t_sig;
    sig(28, 47);
    bus(1'b0, `MMC_PWRUP_ADDR, 64'h0);
    chk(rdv, 1'b0);
    sig(0, 27);
    chk(mode, mmc_pkg::MMC_IDLE2);
    // the tail may look like a signature start; a read makes the next attempt start clean
    bus(1'b0, `MMC_PWRUP_ADDR, 64'h0);
    sig(0, 47);
    wait_n(1);
    chk(mode, mmc_pkg::MMC_CONFIG);
  endtask
  task automatic t_cfg;
    bus(1'b0, `MMC_REG_MODE, 64'h0);
    chk(rdv, 1'b1);
    chk(rdd, 64'(mmc_pkg::MMC_CONFIG));
    bus(1'b1, `MMC_REG_CKE, 64'h2);
    chk({clo, chi}, 2'h1);
    bus(1'b1, `MMC_REG_CKE, 64'h3);
    wait_n(1);
    chk({clo, chi}, 2'h3);
    @(posedge clk_sys_i);
    pirq <= 1'b1;
    wait_n(1);
    chk({irq_o, oe, line}, 3'h2);
    @(posedge clk_sys_i);
    pirq <= 1'b0;
    busy <= 1'b1;
    bus(1'b1, `MMC_REG_SWITCH, 64'hff);
    s = stall;
    chk(sw, 16'h00ff);
    chk({pb.data, pb.mask}, {32'h0000_00ff, 4'hf});
    wait_n(1);
    chk(s, 1'b1);
    chk(stall, 1'b0);
    @(posedge clk_sys_i);
    busy <= 1'b0;
    bus(1'b1, `MMC_REG_EXEC, 64'h1);
    chk(mode, mmc_pkg::MMC_EXEC);
    wait_n(1);
    chk(run, 1'b1);
    bus(1'b0, `MMC_REG_EXEC, 64'h0);
    chk(rdd, {32'h0000_0000, pdat});
    bus(1'b1, `MMC_REG_MODE, 64'h0);
    chk(mode, mmc_pkg::MMC_IDLE2);
    chk(run, 1'b0);
    // register outputs clear one edge after the mode has left
    wait_n(1);
    chk({clo, chi, sw}, 18'h00000);
    sig(0, 47);
    wait_n(1);
    chk(mode, mmc_pkg::MMC_CONFIG);
  endtask
  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    wait_n(2);
    t_std;
    t_tog;
    t_sig;
    t_cfg;
    close_out;
  end
  // run needs about 2200 cycles; cut off well beyond that
  initial
  begin
    #100000;
    n_errors++;
    close_out;
  end
endmodule
`default_nettype wire
